// ==== rtl/dlc_regs.vh ====
/*
  Register map, field positions, reset values and decode scales for the
  deceleration and loop configuration bank.
  Assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef DLC_REGS_VH
`define DLC_REGS_VH

// Register indices; the byte address on APB is four times the index
`define DLC_IDX_DECEL 8'h8C
`define DLC_IDX_GAIN 8'h8E
`define DLC_IDX_POWER 8'h90
`define DLC_IDX_STATUS 8'h94
`define DLC_ADDR_W 12

// Reset values
`define DLC_RST_DECEL 32'h00000000
`define DLC_RST_GAIN 32'h00000000
`define DLC_RST_POWER 32'h00000000

// Writable bits per register; reserved bits stay zero
`define DLC_WMASK_DECEL 32'h800FFFFF
`define DLC_WMASK_GAIN 32'hBFFFFFFF
`define DLC_WMASK_POWER 32'hFFFFFFFF

// Shared parity position
`define DLC_PARITY_BIT 31

// Deceleration register fields
`define DLC_BLANK_BIT 19
`define DLC_WIN_HI 18
`define DLC_WIN_LO 16
`define DLC_THR_HI 15
`define DLC_THR_LO 13
`define DLC_LOWLIM_HI 12
`define DLC_LOWLIM_LO 9
`define DLC_TAPER_BIT 8
`define DLC_DECEL_EN_BIT 7
`define DLC_UPLIM_HI 6
`define DLC_UPLIM_LO 3
`define DLC_DELTA_HI 2
`define DLC_DELTA_LO 0

// Loop gain register fields
`define DLC_KP_HI 29
`define DLC_KP_LO 20
`define DLC_KI_HI 19
`define DLC_KI_LO 8
`define DLC_VMAX_HI 7
`define DLC_VMAX_LO 5
`define DLC_VMIN_HI 4
`define DLC_VMIN_LO 2
`define DLC_MODE_HI 1
`define DLC_MODE_LO 0

// Loop selector codes
`define DLC_MODE_OFF 2'h0
`define DLC_MODE_SPEED 2'h1
`define DLC_MODE_POWER 2'h2
`define DLC_MODE_RSVD 2'h3

// Percent table kinds, results in tenths of a percent
`define DLC_PCT_WINDOW 2'h0
`define DLC_PCT_CEILING 2'h1
`define DLC_PCT_DELTA 2'h2
`define DLC_PCT_FULL 10'h3E8
`define DLC_PCT_CEIL_STEP 10'h032

// Current limit scale: millivolts per code step
`define DLC_MV_PER_STEP 11'h064

// Gain divisors: effective gain is the stored value over these
`define DLC_KP_DIVISOR 10000
`define DLC_KI_DIVISOR 1000000

// Status register bits
`define DLC_ST_MODE_HI 1
`define DLC_ST_MODE_LO 0
`define DLC_ST_MODE_RSVD 2
`define DLC_ST_DECEL_ON 3
`define DLC_ST_BLANK_ON 4
`define DLC_ST_TAPER_ON 5
`define DLC_ST_UPLIM_NA 6
`define DLC_ST_LOWLIM_NA 7
`define DLC_ST_LIM_ORDER 8

`endif

// ==== rtl/dlc_pct_decode.v ====
/*
  Decodes a three-bit percent code into tenths of a percent.
  Purely combinational; the caller registers the result.
*/
`include "dlc_regs.vh"

module dlc_pct_decode (
  // Code and table kind
  input wire [2:0] code_i,
  input wire [1:0] kind_i,
  // Result in tenths of a percent
  output reg [9:0] pct_o
);

  always @* begin
    pct_o = 10'h000;
    case (kind_i)
      `DLC_PCT_WINDOW: begin
        case (code_i)
          3'h0: pct_o = 10'h000;
          3'h1: pct_o = 10'h019;
          3'h2: pct_o = 10'h032;
          3'h3: pct_o = 10'h04B;
          3'h4: pct_o = 10'h064;
          3'h5: pct_o = 10'h096;
          3'h6: pct_o = 10'h0C8;
          default: pct_o = 10'h0FA;
        endcase
      end
      // Linear 5 % steps down from full scale
      `DLC_PCT_CEILING: pct_o = `DLC_PCT_FULL - {7'h00, code_i} * `DLC_PCT_CEIL_STEP;
      `DLC_PCT_DELTA: begin
        case (code_i)
          3'h0: pct_o = 10'h005;
          3'h1: pct_o = 10'h00A;
          3'h2: pct_o = 10'h00F;
          3'h3: pct_o = 10'h014;
          3'h4: pct_o = 10'h019;
          3'h5: pct_o = 10'h01E;
          3'h6: pct_o = 10'h028;
          default: pct_o = 10'h032;
        endcase
      end
      default: pct_o = 10'h000;
    endcase
  end

endmodule

// ==== rtl/dlc_curr_decode.v ====
/*
  Decodes a four-bit current limit code into a sense voltage in millivolts.
  Code zero means no limit; dividing by the sense amplifier gain is left
  to the consumer, which knows that gain.
*/
`include "dlc_regs.vh"

module dlc_curr_decode (
  // Code
  input wire [3:0] code_i,
  // Sense voltage and validity
  output wire [10:0] mv_o,
  output wire valid_o
);

  wire [14:0] product;

  assign product = {11'h000, code_i} * {4'h0, `DLC_MV_PER_STEP};
  assign mv_o = product[10:0];
  assign valid_o = (code_i != 4'h0);

endmodule

// ==== rtl/dlc_reg_bank.v ====
/*
  Configuration bank for fast deceleration and the speed/power loop,
  reached as an APB slave, with decoded fields registered for the
  commutation and regulation logic.
  Assumes an APB master on clk_i; zero wait states; registers indexed by
  their printed offsets, byte address is four times the index.
*/
// Register access over APB was decided locally.
`include "dlc_regs.vh"

// Notes on behaviour
// - Bit 19 enables phase comparator blanking during fast deceleration.
// - Bits 18-16 pick deceleration duty window 0 to 25 percent.
// - Bits 15-13 pick duty threshold, 100 percent minus 5 per code.
// - Bits 12-9 lower current limit, 0.1 V per code, zero means none.
// - Bit 8 lets the current limit taper during fast deceleration.
// - Bit 7 enables fast deceleration.
// - Bits 6-3 upper current limit, 0.1 V per code, zero means none.
// - Bits 2-0 pick exit speed delta 0.5 to 5 percent.
// - Ten-bit proportional gain at 29-20, stored value over 10000.
// - Twelve-bit integral gain at 19-8, stored value over 1000000.
// - Bits 7-5 upper loop clamp, 100 percent minus 5 per code.
// - Bits 4-2 lower loop clamp 0 to 25 percent.
// - Bits 1-0 select off, speed or power loop; code 3 reserved.
// - Deceleration register sits at offset 8Ch and resets to zero.
module dlc_reg_bank (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`DLC_ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire pready_o,
  output reg [31:0] prdata_o,
  output wire pslverr_o,
  // Fast deceleration controls
  output reg quick_slowdown_enable_o,
  output reg comparator_blank_enable_o,
  output reg decel_current_taper_enable_o,
  output reg [9:0] decel_duty_window_o,
  output reg [9:0] decel_duty_threshold_o,
  output reg [9:0] decel_exit_speed_delta_o,
  output reg [10:0] decel_current_lower_limit_o,
  output reg decel_current_lower_valid_o,
  output reg [10:0] decel_current_upper_limit_o,
  output reg decel_current_upper_valid_o,
  // Loop controls
  output reg [9:0] loop_proportional_gain_o,
  output reg [11:0] loop_integral_gain_o,
  output reg [9:0] loop_output_upper_clamp_o,
  output reg [9:0] loop_output_lower_clamp_o,
  output reg loop_speed_select_o,
  output reg loop_power_select_o,
  // Constant power settings, consumed elsewhere
  output reg [31:0] power_limit_config_o
);

  reg [31:0] decel_config;
  reg [31:0] loop_gain_config;
  reg [31:0] power_limit_config;
  reg [31:0] status;
  reg [31:0] next_rdata;

  wire setup_phase;
  wire access_phase;
  wire [`DLC_ADDR_W-1:0] word_index;
  wire aligned;
  wire hit_decel;
  wire hit_gain;
  wire hit_power;
  wire hit_status;
  wire mapped;
  wire write_now;

  wire [9:0] win_pct;
  wire [9:0] thr_pct;
  wire [9:0] delta_pct;
  wire [9:0] vmax_pct;
  wire [9:0] vmin_pct;
  wire [10:0] low_mv;
  wire low_valid;
  wire [10:0] up_mv;
  wire up_valid;
  wire [1:0] mode_code;

  // Byte-lane merge with reserved bits forced to zero
  function [31:0] merge_write;
    input [31:0] old_value;
    input [31:0] wdata;
    input [3:0] strb;
    input [31:0] wmask;
    reg [31:0] lane_mask;
    begin
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge_write = ((old_value & ~lane_mask) | (wdata & lane_mask)) & wmask;
    end
  endfunction

  // Index match for one register: index equal; word alignment is checked at each call
  function index_hit;
    input [`DLC_ADDR_W-1:0] index;
    input [7:0] target;
    begin
      index_hit = (index == {{(`DLC_ADDR_W-8){1'b0}}, target});
    end
  endfunction

  // Bus decode
  assign setup_phase = psel_i & ~penable_i;
  assign access_phase = psel_i & penable_i;
  assign word_index = {2'b00, paddr_i[`DLC_ADDR_W-1:2]};
  assign aligned = (paddr_i[1:0] == 2'b00);
  assign hit_decel = aligned & index_hit(word_index, `DLC_IDX_DECEL);
  assign hit_gain = aligned & index_hit(word_index, `DLC_IDX_GAIN);
  assign hit_power = aligned & index_hit(word_index, `DLC_IDX_POWER);
  assign hit_status = aligned & index_hit(word_index, `DLC_IDX_STATUS);
  assign mapped = hit_decel | hit_gain | hit_power | hit_status;
  assign write_now = access_phase & pwrite_i;

  // Zero wait states; the read word is captured during setup
  assign pready_o = 1'b1;
  assign pslverr_o = access_phase & ~mapped;

  // Register writes; only the access edge takes effect
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      decel_config <= `DLC_RST_DECEL;
      loop_gain_config <= `DLC_RST_GAIN;
      power_limit_config <= `DLC_RST_POWER;
    end else if (write_now) begin
      if (hit_decel) begin
        decel_config <= merge_write(decel_config, pwdata_i, pstrb_i,
                                    `DLC_WMASK_DECEL);
      end else if (hit_gain) begin
        loop_gain_config <= merge_write(loop_gain_config, pwdata_i, pstrb_i,
                                        `DLC_WMASK_GAIN);
      end else if (hit_power) begin
        power_limit_config <= merge_write(power_limit_config, pwdata_i,
                                          pstrb_i, `DLC_WMASK_POWER);
      end
    end
  end

  // Read mux; status is read-only and unmapped reads return zero
  always @* begin
    next_rdata = 32'h00000000;
    if (hit_decel) begin
      next_rdata = decel_config;
    end else if (hit_gain) begin
      next_rdata = loop_gain_config;
    end else if (hit_power) begin
      next_rdata = power_limit_config;
    end else if (hit_status) begin
      next_rdata = status;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (setup_phase & ~pwrite_i) begin
      prdata_o <= next_rdata;
    end
  end

  // Table decoders
  dlc_pct_decode u_win (
    .code_i(decel_config[`DLC_WIN_HI:`DLC_WIN_LO]),
    .kind_i(`DLC_PCT_WINDOW),
    .pct_o(win_pct)
  );

  dlc_pct_decode u_thr (
    .code_i(decel_config[`DLC_THR_HI:`DLC_THR_LO]),
    .kind_i(`DLC_PCT_CEILING),
    .pct_o(thr_pct)
  );

  dlc_pct_decode u_delta (
    .code_i(decel_config[`DLC_DELTA_HI:`DLC_DELTA_LO]),
    .kind_i(`DLC_PCT_DELTA),
    .pct_o(delta_pct)
  );

  dlc_pct_decode u_vmax (
    .code_i(loop_gain_config[`DLC_VMAX_HI:`DLC_VMAX_LO]),
    .kind_i(`DLC_PCT_CEILING),
    .pct_o(vmax_pct)
  );

  dlc_pct_decode u_vmin (
    .code_i(loop_gain_config[`DLC_VMIN_HI:`DLC_VMIN_LO]),
    .kind_i(`DLC_PCT_WINDOW),
    .pct_o(vmin_pct)
  );

  dlc_curr_decode u_low (
    .code_i(decel_config[`DLC_LOWLIM_HI:`DLC_LOWLIM_LO]),
    .mv_o(low_mv),
    .valid_o(low_valid)
  );

  dlc_curr_decode u_up (
    .code_i(decel_config[`DLC_UPLIM_HI:`DLC_UPLIM_LO]),
    .mv_o(up_mv),
    .valid_o(up_valid)
  );

  assign mode_code = loop_gain_config[`DLC_MODE_HI:`DLC_MODE_LO];

  // Fast deceleration outputs; blanking and taper only act while enabled
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      quick_slowdown_enable_o <= 1'b0;
      comparator_blank_enable_o <= 1'b0;
      decel_current_taper_enable_o <= 1'b0;
      decel_duty_window_o <= 10'h000;
      decel_duty_threshold_o <= `DLC_PCT_FULL;
      decel_exit_speed_delta_o <= 10'h005;
      decel_current_lower_limit_o <= 11'h000;
      decel_current_lower_valid_o <= 1'b0;
      decel_current_upper_limit_o <= 11'h000;
      decel_current_upper_valid_o <= 1'b0;
    end else begin
      quick_slowdown_enable_o <= decel_config[`DLC_DECEL_EN_BIT];
      comparator_blank_enable_o <= decel_config[`DLC_DECEL_EN_BIT] &
                                   decel_config[`DLC_BLANK_BIT];
      decel_current_taper_enable_o <= decel_config[`DLC_DECEL_EN_BIT] &
                                      decel_config[`DLC_TAPER_BIT];
      decel_duty_window_o <= win_pct;
      decel_duty_threshold_o <= thr_pct;
      decel_exit_speed_delta_o <= delta_pct;
      decel_current_lower_limit_o <= low_mv;
      decel_current_lower_valid_o <= low_valid;
      decel_current_upper_limit_o <= up_mv;
      decel_current_upper_valid_o <= up_valid;
    end
  end

  // Loop outputs; the reserved selector is treated as loop off
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      loop_proportional_gain_o <= 10'h000;
      loop_integral_gain_o <= 12'h000;
      loop_output_upper_clamp_o <= `DLC_PCT_FULL;
      loop_output_lower_clamp_o <= 10'h000;
      loop_speed_select_o <= 1'b0;
      loop_power_select_o <= 1'b0;
      power_limit_config_o <= `DLC_RST_POWER;
    end else begin
      loop_proportional_gain_o <= loop_gain_config[`DLC_KP_HI:`DLC_KP_LO];
      loop_integral_gain_o <= loop_gain_config[`DLC_KI_HI:`DLC_KI_LO];
      loop_output_upper_clamp_o <= vmax_pct;
      loop_output_lower_clamp_o <= vmin_pct;
      loop_speed_select_o <= (mode_code == `DLC_MODE_SPEED);
      loop_power_select_o <= (mode_code == `DLC_MODE_POWER);
      power_limit_config_o <= power_limit_config;
    end
  end

  // Status word for software: effective settings and limit sanity
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status <= 32'h00000000;
    end else begin
      status <= 32'h00000000;
      if (mode_code == `DLC_MODE_RSVD) begin
        status[`DLC_ST_MODE_HI:`DLC_ST_MODE_LO] <= `DLC_MODE_OFF;
      end else begin
        status[`DLC_ST_MODE_HI:`DLC_ST_MODE_LO] <= mode_code;
      end
      status[`DLC_ST_MODE_RSVD] <= (mode_code == `DLC_MODE_RSVD);
      status[`DLC_ST_DECEL_ON] <= decel_config[`DLC_DECEL_EN_BIT];
      status[`DLC_ST_BLANK_ON] <= decel_config[`DLC_DECEL_EN_BIT] &
                                  decel_config[`DLC_BLANK_BIT];
      status[`DLC_ST_TAPER_ON] <= decel_config[`DLC_DECEL_EN_BIT] &
                                  decel_config[`DLC_TAPER_BIT];
      status[`DLC_ST_UPLIM_NA] <= ~up_valid;
      status[`DLC_ST_LOWLIM_NA] <= ~low_valid;
      // A taper floor above the ceiling cannot be honoured downstream
      status[`DLC_ST_LIM_ORDER] <= low_valid & up_valid & (low_mv > up_mv);
    end
  end

endmodule

// ==== tb/dlc_reg_bank_assertions.sv ====
/*
  Concurrent checks on the ports of the deceleration and loop config bank.
  Assumes an APB master on clk_i and full-word writes for the decoded checks.
*/
`include "dlc_regs.vh"

module dlc_reg_bank_assertions (
  // Clock, reset and bus
  input wire clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`DLC_ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  // Decoded outputs
  input wire quick_slowdown_enable_o,
  input wire comparator_blank_enable_o,
  input wire decel_current_taper_enable_o,
  input wire [9:0] decel_duty_threshold_o,
  input wire [10:0] decel_current_lower_limit_o,
  input wire [10:0] decel_current_upper_limit_o,
  input wire decel_current_upper_valid_o,
  input wire [9:0] loop_proportional_gain_o,
  input wire [9:0] loop_output_upper_clamp_o,
  input wire loop_speed_select_o,
  input wire loop_power_select_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Only full-word writes qualify, so every field is known two edges later
  wire wr_full = psel_i && penable_i && pwrite_i && pstrb_i == 4'hF;
  wire dec_wr = wr_full && paddr_i == 12'h230;
  wire gain_wr = wr_full && paddr_i == 12'h238;

  chk_decel_enable: assert property (dec_wr |-> ##2
    quick_slowdown_enable_o == $past(pwdata_i[7], 2)) else $error("decel enable wrong");
  chk_blank_gated: assert property (dec_wr |-> ##2
    comparator_blank_enable_o == ($past(pwdata_i[19], 2) && $past(pwdata_i[7], 2)))
    else $error("blanking wrong");
  chk_taper_gated: assert property (dec_wr |-> ##2
    decel_current_taper_enable_o == ($past(pwdata_i[8], 2) && $past(pwdata_i[7], 2)))
    else $error("taper wrong");
  chk_thr_step: assert property (dec_wr |-> ##2
    decel_duty_threshold_o == 10'h3E8 - 10'h032 * $past(pwdata_i[15:13], 2))
    else $error("threshold wrong");
  chk_lower_mv: assert property (dec_wr |-> ##2
    decel_current_lower_limit_o == 11'h064 * $past(pwdata_i[12:9], 2))
    else $error("lower limit wrong");
  chk_upper_valid: assert property (
    decel_current_upper_valid_o == (decel_current_upper_limit_o != 11'h000))
    else $error("upper valid wrong");
  chk_kp_raw: assert property (gain_wr |-> ##2
    loop_proportional_gain_o == $past(pwdata_i[29:20], 2)) else $error("kp wrong");
  chk_clamp_step: assert property (gain_wr |-> ##2
    loop_output_upper_clamp_o == 10'h3E8 - 10'h032 * $past(pwdata_i[7:5], 2))
    else $error("upper clamp wrong");
  chk_mode_select: assert property (gain_wr |-> ##2
    loop_speed_select_o == ($past(pwdata_i[1:0], 2) == 2'h1) &&
    loop_power_select_o == ($past(pwdata_i[1:0], 2) == 2'h2)) else $error("mode wrong");
endmodule

bind dlc_reg_bank dlc_reg_bank_assertions u_chk (.clk_i, .rst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .quick_slowdown_enable_o,
  .comparator_blank_enable_o, .decel_current_taper_enable_o, .decel_duty_threshold_o,
  .decel_current_lower_limit_o, .decel_current_upper_limit_o, .decel_current_upper_valid_o,
  .loop_proportional_gain_o, .loop_output_upper_clamp_o, .loop_speed_select_o,
  .loop_power_select_o);

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the config bank: APB writes and reads, decode checks.
  Assumes the bank answers APB with zero or more wait states and one clock.
*/
`include "dlc_regs.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [3:0] pstrb_i = 4'h0;
  logic pready_o, pslverr_o, quick_slowdown_enable_o, comparator_blank_enable_o;
  logic decel_current_taper_enable_o, decel_current_lower_valid_o;
  logic decel_current_upper_valid_o, loop_speed_select_o, loop_power_select_o;
  logic [31:0] prdata_o, power_limit_config_o, rd, v, m;
  logic [9:0] decel_duty_window_o, decel_duty_threshold_o, decel_exit_speed_delta_o;
  logic [9:0] loop_proportional_gain_o, loop_output_upper_clamp_o, loop_output_lower_clamp_o;
  logic [10:0] decel_current_lower_limit_o, decel_current_upper_limit_o;
  logic [11:0] loop_integral_gain_o;
  logic er;
  int mismatches = 0;
  int n_tests = 0;
  int win_t[8] = '{0, 25, 50, 75, 100, 150, 200, 250};
  int dl_t[8] = '{5, 10, 15, 20, 25, 30, 40, 50};
  localparam logic [11:0] A_DEC = 12'({`DLC_IDX_DECEL, 2'b00});
  localparam logic [11:0] A_GAIN = 12'({`DLC_IDX_GAIN, 2'b00});
  localparam logic [11:0] A_POW = 12'({`DLC_IDX_POWER, 2'b00});
  localparam logic [11:0] A_ST = 12'({`DLC_IDX_STATUS, 2'b00});

  dlc_reg_bank u_dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .quick_slowdown_enable_o,
    .comparator_blank_enable_o, .decel_current_taper_enable_o, .decel_duty_window_o,
    .decel_duty_threshold_o, .decel_exit_speed_delta_o, .decel_current_lower_limit_o,
    .decel_current_lower_valid_o, .decel_current_upper_limit_o, .decel_current_upper_valid_o,
    .loop_proportional_gain_o, .loop_integral_gain_o, .loop_output_upper_clamp_o,
    .loop_output_lower_clamp_o, .loop_speed_select_o, .loop_power_select_o,
    .power_limit_config_o);

  initial forever #25 clk_i = ~clk_i;

  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_flag(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Holds the request until pready is seen; a stuck slave ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      report_and_stop;
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    report_and_stop;
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, A_DEC, 32'h00000000, 4'h0, rd, er);
    cmp_val(rd, 32'h00000000);
    cmp_val(32'(decel_duty_threshold_o), 32'h000003E8);
    cmp_val(32'(decel_exit_speed_delta_o), 32'h00000005);
    cmp_val(32'(loop_output_upper_clamp_o), 32'h000003E8);
    // Each row sweeps one code of every field; reserved bits are written as ones
    for (int i = 0; i < 8; i++) begin
      logic [2:0] c;
      c = 3'(i);
      v = {c[0], 11'h7FF, c[1], c, ~c, {c, c[2]}, c[2], c[0] ^ c[1], {~c, ~c[0]}, c};
      apb(1'b1, A_DEC, v, 4'hF, rd, er);
      apb(1'b0, A_DEC, 32'h00000000, 4'h0, rd, er);
      m = v & 32'h800FFFFF;
      cmp_val(rd, m);
      cmp_flag(er, 1'b0);
      cmp_flag(quick_slowdown_enable_o, m[7]);
      cmp_flag(comparator_blank_enable_o, m[19] & m[7]);
      cmp_flag(decel_current_taper_enable_o, m[8] & m[7]);
      cmp_val(32'(decel_duty_window_o), 32'(win_t[m[18:16]]));
      cmp_val(32'(decel_duty_threshold_o), 32'(1000 - 50 * m[15:13]));
      cmp_val(32'(decel_current_lower_limit_o), 32'(100 * m[12:9]));
      cmp_flag(decel_current_lower_valid_o, m[12:9] != 4'h0);
      cmp_val(32'(decel_current_upper_limit_o), 32'(100 * m[6:3]));
      cmp_flag(decel_current_upper_valid_o, m[6:3] != 4'h0);
      cmp_val(32'(decel_exit_speed_delta_o), 32'(dl_t[m[2:0]]));
      v = {c[0], 1'b1, {c, 7'h55}, {~c, 9'h0A5}, c, ~c, c[1:0]};
      apb(1'b1, A_GAIN, v, 4'hF, rd, er);
      apb(1'b0, A_GAIN, 32'h00000000, 4'h0, rd, er);
      cmp_val(rd, v & 32'hBFFFFFFF);
      cmp_val(32'(loop_proportional_gain_o), 32'(v[29:20]));
      cmp_val(32'(loop_integral_gain_o), 32'(v[19:8]));
      cmp_val(32'(loop_output_upper_clamp_o), 32'(1000 - 50 * v[7:5]));
      cmp_val(32'(loop_output_lower_clamp_o), 32'(win_t[v[4:2]]));
      cmp_flag(loop_speed_select_o, v[1:0] == 2'h1);
      cmp_flag(loop_power_select_o, v[1:0] == 2'h2);
    end
    // Only byte lane 0 may land, so the upper fields keep the last row
    apb(1'b1, A_DEC, 32'hFFFFFFFF, 4'h1, rd, er);
    apb(1'b0, A_DEC, 32'h00000000, 4'h0, rd, er);
    cmp_val(rd, (m & 32'hFFFFFF00) | 32'h000000FF);
    cmp_flag(quick_slowdown_enable_o, 1'b1);
    apb(1'b1, A_POW, 32'hFFFFFFFF, 4'hF, rd, er);
    apb(1'b0, A_POW, 32'h00000000, 4'h0, rd, er);
    cmp_val(rd, 32'hFFFFFFFF);
    cmp_val(power_limit_config_o, 32'hFFFFFFFF);
    // Last row left selector code 3; lane 0 set enable, blanking and taper stay set
    apb(1'b1, A_ST, 32'hFFFFFFFF, 4'hF, rd, er);
    cmp_flag(er, 1'b0);
    apb(1'b0, A_ST, 32'h00000000, 4'h0, rd, er);
    cmp_val(rd, 32'h0000003C);
    apb(1'b1, 12'h100, 32'hFFFFFFFF, 4'hF, rd, er);
    cmp_flag(er, 1'b1);
    apb(1'b0, A_DEC + 12'h002, 32'h00000000, 4'h0, rd, er);
    cmp_flag(er, 1'b1);
    cmp_val(rd, 32'h00000000);
    // Reset in mid-run must clear every stored bit again
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, A_DEC, 32'h00000000, 4'h0, rd, er);
    cmp_val(rd, 32'h00000000);
    apb(1'b0, A_POW, 32'h00000000, 4'h0, rd, er);
    cmp_val(rd, 32'h00000000);
    cmp_val(power_limit_config_o, 32'h00000000);
    cmp_flag(quick_slowdown_enable_o, 1'b0);
    report_and_stop;
  end
endmodule
